// ===== shared/dgp_pkg.sv
package dgp_pkg;

  // ****************************************
  // register map (byte addresses on the port)
  // ****************************************
  localparam logic [15:0] P6_DATA_ADDR = 16'hFFD9;
  localparam logic [15:0] P7_DATA_ADDR = 16'hFFDA;
  localparam logic [15:0] P6_DIR_ADDR  = 16'hFFE9;
  localparam logic [15:0] P7_DIR_ADDR  = 16'hFFEA;

  // ****************************************
  // reset values and field layout
  // ****************************************
  localparam logic [7:0] P6_DATA_RST   = 8'h00;
  localparam logic [7:0] P6_DIR_RST    = 8'h00;
  localparam logic [7:0] P7_DATA_RST   = 8'h00;
  localparam logic [7:0] P7_DIR_RST    = 8'h00;
  localparam logic [7:0] WO_READ_VAL   = 8'hFF;
  localparam logic [7:0] P7_USED_MASK  = 8'hF8;
  localparam logic [7:0] UNMAPPED_VAL  = 8'h00;
  localparam int         P7_TMR_OUT_BIT = 6;
  localparam int         P7_TMR_CLK_BIT = 5;
  localparam int         P7_TMR_RST_BIT = 4;
  localparam logic [3:0] TMR_SEL_OFF   = 4'h0;

  // ****************************************
  // power modes
  // ****************************************
  typedef enum logic [2:0] {
    DGP_ACTIVE,
    DGP_SUBACTIVE,
    DGP_SLEEP,
    DGP_SUBSLEEP,
    DGP_STANDBY,
    DGP_WATCH
  } dgp_mode_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } dgp_bus_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dgp_pins_t;

endpackage

// ===== rtl/dgp_port.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - port 6 read gives latch where output, synchronised pin where input
// - port 6 data latch clears to zero at reset
// - port 6 direction one drives pin from latch, zero makes input
// - port 6 direction register is write-only and reads all ones
// - port 6 direction clears to zero at reset, all pins inputs
// - port 6 floats in reset (no pull-up) and standby/watch (pull-up high), holds in sleep
// - port 7 data bits 2..0 reserved, read zero, ignore writes
// - port 7 read gives latch where output, pin level where input
// - port 7 direction bits 7..3 select output or input
// - port 7 direction register is write-only and reads all ones
// - port 7 data and direction clear to zero at reset
// - nonzero timer select puts timer output on port 7 pin 6
// - port 7 pins 5 and 4 feed timer clock and reset inputs
// - port 7 floats in reset/standby, holds in sleep and watch
module dgp_port
  import dgp_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       clk_en_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire dgp_mode_t   mode_i,
  input  wire logic [7:0]  p6_pullup_i,
  input  wire logic [3:0]  timer_output_select_i,
  input  wire logic        timer_wave_out_i,
  output logic             timer_ext_clock_in_o,
  output logic             timer_counter_reset_in_o,
  input  wire logic [7:0]  p6_pin_i,
  output logic      [7:0]  p6_pin_o,
  output logic      [7:0]  p6_pin_oe_o,
  input  wire logic [7:0]  p7_pin_i,
  output logic      [7:0]  p7_pin_o,
  output logic      [7:0]  p7_pin_oe_o
);

  // ****************************************
  // bus decode
  // ****************************************
  dgp_bus_t bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  wire hit_p6d = bus.addr == P6_DATA_ADDR;
  wire hit_p7d = bus.addr == P7_DATA_ADDR;
  wire hit_p6c = bus.addr == P6_DIR_ADDR;
  wire hit_p7c = bus.addr == P7_DIR_ADDR;

  logic [7:0] port6_data_latch_ff;
  logic [7:0] port6_direction_ff;
  logic [7:0] port7_data_latch_ff;
  logic [7:0] port7_direction_ff;
  logic [7:0] p6_meta_ff;
  logic [7:0] p6_sync_ff;
  logic [7:0] p7_meta_ff;
  logic [7:0] p7_sync_ff;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port6_data_latch_ff <= P6_DATA_RST;
      port6_direction_ff  <= P6_DIR_RST;
      port7_data_latch_ff <= P7_DATA_RST;
      port7_direction_ff  <= P7_DIR_RST;
    end else if (clk_en_i && bus.wr) begin
      if (hit_p6d) begin
        port6_data_latch_ff <= bus.wdata;
      end
      if (hit_p6c) begin
        port6_direction_ff <= bus.wdata;
      end
      if (hit_p7d) begin
        port7_data_latch_ff <= bus.wdata & P7_USED_MASK;
      end
      if (hit_p7c) begin
        port7_direction_ff <= bus.wdata & P7_USED_MASK;
      end
    end
  end

  // ****************************************
  // pin input synchronisers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p6_meta_ff <= 8'h00;
      p6_sync_ff <= 8'h00;
      p7_meta_ff <= 8'h00;
      p7_sync_ff <= 8'h00;
    end else if (clk_en_i) begin
      p6_meta_ff <= p6_pin_i;
      p6_sync_ff <= p6_meta_ff;
      p7_meta_ff <= p7_pin_i;
      p7_sync_ff <= p7_meta_ff;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  wire [7:0] p6_view = (port6_direction_ff & port6_data_latch_ff)
                     | (~port6_direction_ff & p6_sync_ff);
  wire [7:0] p7_view = ((port7_direction_ff & port7_data_latch_ff)
                     | (~port7_direction_ff & p7_sync_ff))
                     & P7_USED_MASK;
  wire [7:0] nxt_rdata = hit_p6d ? p6_view :
                         hit_p7d ? p7_view :
                         (hit_p6c || hit_p7c) ? WO_READ_VAL :
                         UNMAPPED_VAL;

  logic [7:0] rdata_ff;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 8'h00;
    end else if (clk_en_i) begin
      rdata_ff <= bus.rd ? nxt_rdata : 8'h00;
    end
  end
  assign rdata_o = rdata_ff;

  // ****************************************
  // pin drive per power mode
  // ****************************************
  // timer pin override applies before the mode gating, so a hold keeps it
  wire       tmr_on    = timer_output_select_i != TMR_SEL_OFF;
  wire       run_mode  = (mode_i == DGP_ACTIVE) || (mode_i == DGP_SUBACTIVE);
  wire       p7_float  = (mode_i == DGP_STANDBY);
  wire       p6_float  = (mode_i == DGP_STANDBY) ||
                         (mode_i == DGP_WATCH);
  wire [7:0] p6_oe_run = port6_direction_ff;
  wire [7:0] p7_dat_run;
  wire [7:0] p7_oe_run;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_p7
      if (gi == P7_TMR_OUT_BIT) begin : g_tmr
        assign p7_dat_run[gi] = tmr_on ? timer_wave_out_i
                                       : port7_data_latch_ff[gi];
        assign p7_oe_run[gi]  = tmr_on | port7_direction_ff[gi];
      end else begin : g_io
        assign p7_dat_run[gi] = port7_data_latch_ff[gi];
        assign p7_oe_run[gi]  = port7_direction_ff[gi];
      end
    end
  endgenerate

  dgp_pins_t p6_ff;
  dgp_pins_t p7_ff;
  dgp_pins_t nxt_p6;
  dgp_pins_t nxt_p7;

  // pull-up is only meaningful on input pins, hence the direction mask
  assign nxt_p6 = run_mode ? '{out: port6_data_latch_ff, oe: p6_oe_run} :
                  p6_float ? '{out: p6_pullup_i & ~port6_direction_ff,
                               oe: p6_pullup_i & ~port6_direction_ff} :
                  p6_ff;
  assign nxt_p7 = run_mode ? '{out: p7_dat_run, oe: p7_oe_run} :
                  p7_float ? '{out: 8'h00, oe: 8'h00} :
                  p7_ff;

  // reset clears oe, so every pin floats while rstn_i is low
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p6_ff <= '0;
      p7_ff <= '0;
    end else if (clk_en_i) begin
      p6_ff <= nxt_p6;
      p7_ff <= nxt_p7;
    end
  end

  // timer inputs come from synchronised pin levels in any direction
  logic tclk_ff;
  logic trst_ff;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tclk_ff <= 1'b0;
      trst_ff <= 1'b0;
    end else if (clk_en_i) begin
      tclk_ff <= p7_sync_ff[P7_TMR_CLK_BIT];
      trst_ff <= p7_sync_ff[P7_TMR_RST_BIT];
    end
  end

  assign p6_pin_o                 = p6_ff.out;
  assign p6_pin_oe_o              = p6_ff.oe;
  assign p7_pin_o                 = p7_ff.out;
  assign p7_pin_oe_o              = p7_ff.oe;
  assign timer_ext_clock_in_o     = tclk_ff;
  assign timer_counter_reset_in_o = trst_ff;

  // ****************************************
  // assertions
  // ****************************************
  a_p6_dir_reads_ones: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && rd_i && hit_p6c) |=> rdata_o == 8'hFF)
    else $error("port 6 direction read not all ones");

  a_p7_dir_reads_ones: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && rd_i && hit_p7c) |=> rdata_o == 8'hFF)
    else $error("port 7 direction read not all ones");

  a_p7_reserved_zero: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && rd_i && hit_p7d) |=> rdata_o[2:0] == 3'h0)
    else $error("port 7 reserved bits not zero");

  a_p6_read_latch: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && rd_i && hit_p6d && port6_direction_ff == 8'hFF)
    |=> rdata_o == $past(port6_data_latch_ff))
    else $error("port 6 output read not from latch");

  a_p6_write_drive: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && wr_i && hit_p6d && run_mode
     && port6_direction_ff == 8'hFF) ##1 clk_en_i && run_mode
    |=> p6_pin_o == $past(wdata_i, 2))
    else $error("port 6 pin not following write");

  a_p7_timer_pin: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && run_mode && tmr_on)
    |=> p7_pin_oe_o[6] && p7_pin_o[6] == $past(timer_wave_out_i))
    else $error("timer output not on port 7 pin 6");

  a_p7_standby_float: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && mode_i == DGP_STANDBY) |=> p7_pin_oe_o == 8'h00)
    else $error("port 7 driving in standby");

  a_p6_sleep_hold: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (mode_i == DGP_SLEEP) |=> $stable(p6_pin_oe_o) && $stable(p6_pin_o))
    else $error("port 6 changed in sleep");

  a_p7_dir_drive: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && run_mode && !tmr_on)
    |=> p7_pin_oe_o == $past(port7_direction_ff))
    else $error("port 7 enables not from direction");

  a_timer_clk_path: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i)
    (clk_en_i && rstn_i) [*4]
    |-> timer_ext_clock_in_o == $past(p7_pin_i[5], 3))
    else $error("timer clock input not tracking pin 5");

  c_p6_output: cover property (@(posedge sys_clk_i)
    run_mode && p6_pin_oe_o != 8'h00);
  c_timer_pin: cover property (@(posedge sys_clk_i)
    run_mode && tmr_on && p7_pin_oe_o[6]);
  c_standby: cover property (@(posedge sys_clk_i)
    mode_i == DGP_STANDBY && p6_pin_oe_o != 8'h00);
  c_watch_hold: cover property (@(posedge sys_clk_i)
    mode_i == DGP_WATCH && p7_pin_oe_o != 8'h00);

endmodule

// ===== bench/dgp_port_test.sv
`timescale 1ns/1ps
module dgp_port_test;
  import dgp_pkg::*;
  logic        sys_clk_i, rstn_i, clk_en_i, wr_i, rd_i, wave, tclk, trst;
  logic        pend;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i, rdata_o, pu, p6i, p6o, p6e, p7i, p7o, p7e, d, v;
  logic [3:0]  tsel;
  dgp_mode_t   mode;
  logic [7:0]  exp_q[$];
  int          num_errors, check_count;

  dgp_port i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .mode_i(mode), .p6_pullup_i(pu),
    .timer_output_select_i(tsel), .timer_wave_out_i(wave),
    .timer_ext_clock_in_o(tclk), .timer_counter_reset_in_o(trst),
    .p6_pin_i(p6i), .p6_pin_o(p6o), .p6_pin_oe_o(p6e),
    .p7_pin_i(p7i), .p7_pin_o(p7o), .p7_pin_oe_o(p7e));

  initial begin
    sys_clk_i = 0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // one bus cycle; reads leave their expected data for the monitor
  task automatic bus(logic w, logic [15:0] a, logic [7:0] x, logic [7:0] e);
    @(posedge sys_clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= x;
    if (!w) exp_q.push_back(e);
  endtask

  task automatic idle(int n);
    @(posedge sys_clk_i);
    wr_i <= 0;
    rd_i <= 0;
    repeat (n) @(posedge sys_clk_i);
  endtask

  // called with reset low; reads back reset contents after release
  task automatic reset_chk();
    chk("p6 oe", 8'h00, p6e);
    chk("p7 oe", 8'h00, p7e);
    @(posedge sys_clk_i);
    rstn_i <= 1;
    idle(3);
    bus(0, P6_DATA_ADDR, 8'h00, p6i);
    bus(0, P6_DIR_ADDR, 8'h00, WO_READ_VAL);
    bus(0, P7_DATA_ADDR, 8'h00, p7i & P7_USED_MASK);
    bus(0, P7_DIR_ADDR, 8'h00, WO_READ_VAL);
    bus(0, 16'hFFDB, 8'h00, UNMAPPED_VAL);
    bus(1, P6_DIR_ADDR, 8'hFF, 8'h00);
    bus(1, P7_DIR_ADDR, 8'hFF, 8'h00);
    bus(0, P6_DATA_ADDR, 8'h00, P6_DATA_RST);
    bus(0, P7_DATA_ADDR, 8'h00, P7_DATA_RST);
    idle(2);
    $display("test reset done");
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // read data monitor
  // ****************************************
  always @(posedge sys_clk_i) begin
    pend <= rd_i && clk_en_i && rstn_i;
  end

  always @(negedge sys_clk_i) begin
    if (pend) begin
      if (exp_q.size() == 0) chk("unexpected read", 8'h00, 8'hFF);
      else chk("rdata", exp_q.pop_front(), rdata_o);
    end
  end

  initial begin
    repeat (4000) @(posedge sys_clk_i);
    num_errors++;
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(38688));
    {rstn_i, wr_i, rd_i, wave, tsel, addr_i, wdata_i} = '0;
    clk_en_i = 1;
    mode = DGP_ACTIVE;
    pu = 8'($urandom);
    p6i = 8'($urandom);
    p7i = 8'($urandom);
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_chk();
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      v = 8'($urandom);
      bus(1, P6_DIR_ADDR, d, 8'h00);
      bus(1, P6_DATA_ADDR, v, 8'h00);
      bus(1, P7_DIR_ADDR, d, 8'h00);
      bus(1, P7_DATA_ADDR, v, 8'h00);
      bus(0, P6_DATA_ADDR, 8'h00, (v & d) | (p6i & ~d));
      bus(0, P7_DATA_ADDR, 8'h00, ((v & d) | (p7i & ~d)) & 8'hF8);
      idle(1);
      @(negedge sys_clk_i);
      chk("p6 oe", d, p6e);
      chk("p6 out", v & d, p6o & d);
      chk("p7 oe", d & 8'hF8, p7e);
      chk("p7 out", v & d & 8'hF8, p7o & (d | 8'h07));
    end
    $display("test direction done");
    bus(1, P6_DIR_ADDR, 8'hFF, 8'h00);
    bus(1, P6_DATA_ADDR, 8'h00, 8'h00);
    bus(1, P6_DATA_ADDR, 8'h5A, 8'h00);
    idle(0);
    @(negedge sys_clk_i);
    chk("p6 out early", 8'h00, p6o);
    @(negedge sys_clk_i);
    chk("p6 out next", 8'h5A, p6o);
    @(posedge sys_clk_i);
    clk_en_i <= 0;
    bus(1, P6_DATA_ADDR, 8'hC3, 8'h00);
    idle(1);
    clk_en_i <= 1;
    bus(0, P6_DATA_ADDR, 8'h00, 8'h5A);
    bus(1, P7_DIR_ADDR, 8'h00, 8'h00);
    idle(1);
    $display("test timing done");
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk_i);
      tsel <= 4'($urandom_range(15, 1));
      wave <= k[0];
      idle(2);
      @(negedge sys_clk_i);
      chk("p7 pin6", {6'h00, 1'b1, k[0]}, {6'h00, p7e[6], p7o[6]});
    end
    @(posedge sys_clk_i);
    tsel <= TMR_SEL_OFF;
    idle(2);
    @(negedge sys_clk_i);
    chk("p7 pin6 oe", 8'h00, {7'h00, p7e[6]});
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      p7i[5:4] <= k[1:0];
      idle(4);
      @(negedge sys_clk_i);
      chk("timer inputs", 8'(k[1:0]), {6'h00, tclk, trst});
    end
    $display("test timer done");
    bus(1, P6_DIR_ADDR, 8'h0F, 8'h00);
    bus(1, P6_DATA_ADDR, 8'hA5, 8'h00);
    bus(1, P7_DIR_ADDR, 8'hF8, 8'h00);
    bus(1, P7_DATA_ADDR, 8'hA8, 8'h00);
    idle(2);
    mode <= DGP_SLEEP;
    idle(1);
    bus(1, P6_DATA_ADDR, 8'h5A, 8'h00);
    bus(1, P7_DATA_ADDR, 8'h50, 8'h00);
    idle(2);
    @(negedge sys_clk_i);
    chk("sleep p6", 8'h05, p6o & 8'h0F);
    chk("sleep p7", 8'hA8, p7o & 8'hF8);
    @(posedge sys_clk_i);
    mode <= DGP_WATCH;
    idle(2);
    @(negedge sys_clk_i);
    chk("watch p7 oe", 8'hF8, p7e);
    chk("watch p6 oe", pu & 8'hF0, p6e);
    @(posedge sys_clk_i);
    mode <= DGP_STANDBY;
    idle(2);
    @(negedge sys_clk_i);
    chk("standby p7 oe", 8'h00, p7e);
    chk("standby p6 oe", pu & 8'hF0, p6e);
    chk("standby p6 out", pu & 8'hF0, p6o);
    @(posedge sys_clk_i);
    mode <= DGP_SUBACTIVE;
    idle(2);
    @(negedge sys_clk_i);
    chk("subactive p6", 8'h0A, p6o & 8'h0F);
    chk("subactive p7", 8'h50, p7o & 8'hF8);
    @(posedge sys_clk_i);
    mode <= DGP_SUBSLEEP;
    idle(1);
    bus(1, P6_DATA_ADDR, 8'hFF, 8'h00);
    idle(2);
    @(negedge sys_clk_i);
    chk("subsleep p6", 8'h0A, p6o & 8'h0F);
    chk("subsleep p7", 8'h50, p7o & 8'hF8);
    $display("test power modes done");
    @(posedge sys_clk_i);
    mode <= DGP_ACTIVE;
    rstn_i <= 0;
    idle(1);
    @(negedge sys_clk_i);
    reset_chk();
    close_out();
  end
endmodule
